// >>> hw/module_control_regs.sv
// Control and status register group of a multi-channel time digitiser.
// Assumes bus strobes and event status come from logic on clk_in; chain
// lines, termination switches, the panel reset and the rotary switch are pins.
//
// Behaviour
// (R1) Chain address register holds upper multicast bits, loads 0xaa on hardware reset.
// (R2) Set register write: ones set control bits, zeros leave them; read returns bits.
// (R3) Clear register write: ones clear control bits, zeros leave them; read same.
// (R4) Bus error flag bit 3 records generated bus errors; software may set it.
// (R5) Select bit chooses rotary switch (zero) or relocation registers (one) as base.
// (R6) Hold reset bit keeps the module in reset until cleared through clear register.
// (R7) Hardware reset clears all control bits; software reset only the bus error flag.
// (R8) Interrupt level uses three low bits, default zero, zero disables interrupts.
// (R9) Acknowledge cycle drives the eight-bit vector; vector defaults zero.
// (R10) Local ready reads one when at least one complete event is stored.
// (R11) Chain ready and busy are the OR of all modules on the chain.
// (R12) Local busy covers conversion, resetting, full buffer, or memory test mode.
// (R13) Slot missing bit shows that no slot address came from the backplane.
// (R14) Purged bit shows that this board finished sending in a chained transfer.
// (R15) Termination bits report all on and all off; both zero means mixed.
// (R16) Threshold flag: trigger value at least stored count and nonzero-level request raised.
// (R17) Stop bit selects readout end: buffer empty or first event trailer.
// (R18) Panel reset scope: zero data reset, one software reset; hardware reset clears.
// (R19) Bus error enable selects ending block transfers with bus error instead of acknowledge.
// (R20) Align bit pads odd-length events with one not-valid word in 32-bit readout.
// (R21) Relocation registers hold address bits 31..24 and 23..16.
// (R22) Any write to the single-shot location causes exactly one module reset.
// (R23) Meaningless register bits ignore writes and read zero.
module module_control_regs
  import ctrl_regs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        iack_in,
  output logic      [15:0] reg_rdata_out,
  output logic             reg_ack_out,
  input  wire logic [4:0]  events_stored_in,
  input  wire logic [4:0]  event_trigger_in,
  input  wire logic        irq_raised_in,
  input  wire logic        converting_in,
  input  wire logic        buffer_full_in,
  input  wire logic        memory_test_in,
  input  wire logic        bus_error_event_in,
  input  wire logic        purged_in,
  input  wire logic        slot_address_missing_in,
  input  wire logic        chain_ready_line_in,
  input  wire logic        chain_busy_line_in,
  input  wire logic        term_all_on_in,
  input  wire logic        term_all_off_in,
  input  wire logic        panel_reset_in,
  input  wire logic [15:0] rotary_base_in,
  output logic      [15:0] base_address_out,
  output logic      [7:0]  chain_address_out,
  output logic      [2:0]  irq_level_out,
  output logic             module_reset_out,
  output logic             data_reset_out,
  output logic             stop_after_first_event_out,
  output logic             bus_error_terminate_enable_out,
  output logic             align_even_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0]  pins_meta;
  logic [5:0]  pins_sync;
  logic [15:0] rotary_meta;
  logic [15:0] rotary_sync;

  // Two stages; only the second stage is read by logic.
  always_ff @(posedge clk_in)
  begin
    pins_meta   <= {panel_reset_in, term_all_off_in, term_all_on_in,
                    chain_busy_line_in, chain_ready_line_in, slot_address_missing_in};
    pins_sync   <= pins_meta;
    rotary_meta <= rotary_base_in;
    rotary_sync <= rotary_meta;
  end

  logic panel_sync;
  assign panel_sync = pins_sync[5];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0]  chain_address;
  logic [15:0] control_bits;
  logic [2:0]  irq_level;
  logic [7:0]  irq_vector;
  logic [6:0]  control_one;
  logic [7:0]  relocate_high;
  logic [7:0]  relocate_low;
  logic        shot_pulse;
  logic        soft_reset;
  logic [7:0]  next_chain_address;
  logic [15:0] next_control_bits;
  logic [2:0]  next_irq_level;
  logic [7:0]  next_irq_vector;
  logic [6:0]  next_control_one;
  logic [7:0]  next_relocate_high;
  logic [7:0]  next_relocate_low;
  logic        next_shot_pulse;
  logic [15:0] ctl_mask;

  // Only the three documented set/clear bits exist; the rest read zero.
  assign ctl_mask = (16'h0001 << BIT_BUS_ERROR_SEEN) | (16'h0001 << BIT_SELECT_ADDRESS)
                  | (16'h0001 << BIT_HOLD_RESET); // see (R23)

  // Software reset sources: held bit, single-shot pulse, panel in full scope.
  assign soft_reset = control_bits[BIT_HOLD_RESET] | shot_pulse
                    | (panel_sync & control_one[BIT_PANEL_RESET_SCOPE]); // see (R6) see (R18) see (R22)

  // Next-state for every writable register.
  always_comb
  begin
    next_chain_address = chain_address;
    next_control_bits  = control_bits;
    next_irq_level     = irq_level;
    next_irq_vector    = irq_vector;
    next_control_one   = control_one;
    next_relocate_high = relocate_high;
    next_relocate_low  = relocate_low;
    next_shot_pulse    = 1'b0;
    if (reg_write_in)
    begin
      if (hit(reg_addr_in, OFF_CHAIN_ADDRESS))
        next_chain_address = reg_wdata_in[7:0]; // see (R1)
      if (hit(reg_addr_in, OFF_SET_ONE))
        next_control_bits = control_bits | (reg_wdata_in & ctl_mask); // see (R2)
      if (hit(reg_addr_in, OFF_CLEAR_ONE))
        next_control_bits = control_bits & ~(reg_wdata_in & ctl_mask); // see (R3)
      if (hit(reg_addr_in, OFF_IRQ_LEVEL))
        next_irq_level = reg_wdata_in[2:0]; // see (R8)
      if (hit(reg_addr_in, OFF_IRQ_VECTOR))
        next_irq_vector = reg_wdata_in[7:0]; // see (R9)
      if (hit(reg_addr_in, OFF_CONTROL_ONE))
        next_control_one = reg_wdata_in[6:0] & 7'h74; // see (R17) see (R19) see (R20)
      if (hit(reg_addr_in, OFF_RELOCATE_HIGH))
        next_relocate_high = reg_wdata_in[7:0]; // see (R21)
      if (hit(reg_addr_in, OFF_RELOCATE_LOW))
        next_relocate_low = reg_wdata_in[7:0]; // see (R21)
      if (hit(reg_addr_in, OFF_SINGLE_SHOT))
        next_shot_pulse = 1'b1; // see (R22)
    end
    // Software reset clears only the bus error flag; a new error wins over it.
    if (soft_reset)
      next_control_bits[BIT_BUS_ERROR_SEEN] = 1'b0; // see (R7)
    if (bus_error_event_in)
      next_control_bits[BIT_BUS_ERROR_SEEN] = 1'b1; // see (R4)
  end

  // Hardware reset restores every register, including the scope bit.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      chain_address <= RST_CHAIN_ADDRESS; // see (R1)
      control_bits  <= 16'h0000; // see (R7)
      irq_level     <= RST_IRQ_LEVEL;
      irq_vector    <= RST_IRQ_VECTOR;
      control_one   <= 7'h00; // see (R18)
      relocate_high <= RST_RELOCATE;
      relocate_low  <= RST_RELOCATE;
      shot_pulse    <= 1'b0;
    end
    else
    begin
      chain_address <= next_chain_address;
      control_bits  <= next_control_bits;
      irq_level     <= next_irq_level;
      irq_vector    <= next_irq_vector;
      control_one   <= next_control_one;
      relocate_high <= next_relocate_high;
      relocate_low  <= next_relocate_low;
      shot_pulse    <= next_shot_pulse;
    end
  end

  // ----------------------------------------
  // Status and read-back
  // ----------------------------------------
  logic [15:0] status_one;
  logic        local_events_available;
  logic        local_busy;
  logic [15:0] next_rdata;
  logic        next_ack;

  assign local_events_available = (events_stored_in != 5'h00); // see (R10)
  assign local_busy = converting_in | module_reset_out | buffer_full_in | memory_test_in; // see (R12)

  // Status word; a chain line is a wired OR, so our own level is folded in.
  always_comb
  begin
    status_one = 16'h0000;
    status_one[BIT_ST_LOCAL_READY]  = local_events_available;
    status_one[BIT_ST_CHAIN_READY]  = pins_sync[1] | local_events_available; // see (R11)
    status_one[BIT_ST_LOCAL_BUSY]   = local_busy;
    status_one[BIT_ST_CHAIN_BUSY]   = pins_sync[2] | local_busy; // see (R11)
    status_one[BIT_ST_SLOT_MISSING] = pins_sync[0]; // see (R13)
    status_one[BIT_ST_PURGED]       = purged_in; // see (R14)
    status_one[BIT_ST_TERM_ON]      = pins_sync[3]; // see (R15)
    status_one[BIT_ST_TERM_OFF]     = pins_sync[4]; // see (R15)
    status_one[BIT_ST_THRESHOLD]    = (event_trigger_in >= events_stored_in) & irq_raised_in
                                    & (irq_level != 3'h0); // see (R16)
  end

  // Read mux; the acknowledge cycle returns the vector in the low byte.
  always_comb
  begin
    next_rdata = 16'h0000;
    next_ack   = reg_read_in | reg_write_in | iack_in;
    if (iack_in)
      next_rdata = {8'h00, irq_vector}; // see (R9)
    else if (reg_read_in)
    begin
      if (hit(reg_addr_in, OFF_CHAIN_ADDRESS))
        next_rdata = {8'h00, chain_address}; // see (R23)
      if (hit(reg_addr_in, OFF_SET_ONE) || hit(reg_addr_in, OFF_CLEAR_ONE))
        next_rdata = control_bits; // see (R2) see (R3)
      if (hit(reg_addr_in, OFF_IRQ_LEVEL))
        next_rdata = {13'h0000, irq_level}; // see (R8)
      if (hit(reg_addr_in, OFF_IRQ_VECTOR))
        next_rdata = {8'h00, irq_vector};
      if (hit(reg_addr_in, OFF_STATUS_ONE))
        next_rdata = status_one;
      if (hit(reg_addr_in, OFF_CONTROL_ONE))
        next_rdata = {9'h000, control_one}; // see (R23)
      if (hit(reg_addr_in, OFF_RELOCATE_HIGH))
        next_rdata = {8'h00, relocate_high};
      if (hit(reg_addr_in, OFF_RELOCATE_LOW))
        next_rdata = {8'h00, relocate_low};
    end
  end

  // Answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= 16'h0000;
      reg_ack_out   <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= next_rdata;
      reg_ack_out   <= next_ack;
    end
  end

  // ----------------------------------------
  // Outputs to the rest of the module
  // ----------------------------------------
  logic [15:0] next_base;
  logic        next_module_reset;
  logic        next_data_reset;

  // Base selection and reset distribution, registered so outputs come from flops.
  always_comb
  begin
    next_base = control_bits[BIT_SELECT_ADDRESS] ? {relocate_high, relocate_low}
                                                 : rotary_sync; // see (R5) see (R21)
    next_module_reset = soft_reset; // see (R6) see (R22)
    next_data_reset   = panel_sync & ~control_one[BIT_PANEL_RESET_SCOPE]; // see (R18)
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      base_address_out <= 16'h0000;
      module_reset_out <= 1'b0;
      data_reset_out   <= 1'b0;
    end
    else
    begin
      base_address_out <= next_base;
      module_reset_out <= next_module_reset;
      data_reset_out   <= next_data_reset;
    end
  end

  // Configuration bits feed the readout engine directly.
  assign chain_address_out              = chain_address;
  assign irq_level_out                  = irq_level; // see (R8)
  assign stop_after_first_event_out     = control_one[BIT_STOP_AFTER_EVENT]; // see (R17)
  assign bus_error_terminate_enable_out = control_one[BIT_BERR_TERMINATE]; // see (R19)
  assign align_even_out                 = control_one[BIT_ALIGN_EVEN]; // see (R20)

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_chain_reset;
    $fell(reset_in) |-> chain_address_out == 8'haa;
  endproperty
  a_chain_reset: assert property (p_chain_reset) else $error("chain address not 0xaa after reset"); // see (R1)

  property p_set_bits;
    reg_write_in && hit(reg_addr_in, OFF_SET_ONE) && reg_wdata_in[BIT_SELECT_ADDRESS]
      |=> control_bits[BIT_SELECT_ADDRESS];
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set write did not set bit"); // see (R2)

  property p_clear_bits;
    reg_write_in && hit(reg_addr_in, OFF_CLEAR_ONE) && reg_wdata_in[BIT_HOLD_RESET]
      |=> !control_bits[BIT_HOLD_RESET];
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear write did not clear bit"); // see (R3)

  property p_berr_event;
    bus_error_event_in |=> control_bits[BIT_BUS_ERROR_SEEN];
  endproperty
  a_berr_event: assert property (p_berr_event) else $error("bus error flag not set"); // see (R4)

  property p_base_select;
    control_bits[BIT_SELECT_ADDRESS] |=> base_address_out == {$past(relocate_high), $past(relocate_low)};
  endproperty
  a_base_select: assert property (p_base_select) else $error("base not from relocation registers"); // see (R5)

  property p_hold_reset;
    control_bits[BIT_HOLD_RESET] |=> module_reset_out;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("held reset not driven"); // see (R6)

  property p_soft_keeps_select;
    soft_reset && !reg_write_in |=> control_bits[BIT_SELECT_ADDRESS] == $past(control_bits[BIT_SELECT_ADDRESS]);
  endproperty
  a_soft_keeps_select: assert property (p_soft_keeps_select) else $error("soft reset altered select"); // see (R7)

  property p_iack_vector;
    iack_in |=> reg_ack_out && reg_rdata_out == {8'h00, $past(irq_vector)};
  endproperty
  a_iack_vector: assert property (p_iack_vector) else $error("vector not driven on acknowledge"); // see (R9)

  property p_threshold_level;
    irq_level == 3'h0 |-> !status_one[BIT_ST_THRESHOLD];
  endproperty
  a_threshold_level: assert property (p_threshold_level) else $error("threshold flag with level zero"); // see (R16)

  property p_single_shot;
    reg_write_in && hit(reg_addr_in, OFF_SINGLE_SHOT) && !control_bits[BIT_HOLD_RESET] && !panel_sync
      |=> shot_pulse ##1 (module_reset_out && !shot_pulse);
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single shot reset not one pulse"); // see (R22)

  c_shot: cover property (reg_write_in && hit(reg_addr_in, OFF_SINGLE_SHOT) ##2 module_reset_out);
  c_relocate: cover property (control_bits[BIT_SELECT_ADDRESS] && relocate_high != 8'h00);
  c_berr_vs_soft: cover property (bus_error_event_in && soft_reset);
  c_iack: cover property (iack_in && irq_level != 3'h0);

endmodule

// >>> hw/ctrl_regs_pkg.sv
// Constants for the module control register group.
// Assumes a 16-bit register port addressed by byte offset from the base.
package ctrl_regs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] OFF_CHAIN_ADDRESS  = 16'h1004;
  localparam logic [15:0] OFF_SET_ONE        = 16'h1006;
  localparam logic [15:0] OFF_CLEAR_ONE      = 16'h1008;
  localparam logic [15:0] OFF_IRQ_LEVEL      = 16'h100a;
  localparam logic [15:0] OFF_IRQ_VECTOR     = 16'h100c;
  localparam logic [15:0] OFF_STATUS_ONE     = 16'h100e;
  localparam logic [15:0] OFF_CONTROL_ONE    = 16'h1010;
  localparam logic [15:0] OFF_RELOCATE_HIGH  = 16'h1012;
  localparam logic [15:0] OFF_RELOCATE_LOW   = 16'h1014;
  localparam logic [15:0] OFF_SINGLE_SHOT    = 16'h1016;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_CHAIN_ADDRESS  = 8'haa;
  localparam logic [2:0]  RST_IRQ_LEVEL      = 3'h0;
  localparam logic [7:0]  RST_IRQ_VECTOR     = 8'h00;
  localparam logic [7:0]  RST_RELOCATE       = 8'h00;

  // ----------------------------------------
  // Set/clear control bit positions
  // ----------------------------------------
  localparam int BIT_BUS_ERROR_SEEN  = 3;
  localparam int BIT_SELECT_ADDRESS  = 4;
  localparam int BIT_HOLD_RESET      = 7;

  // ----------------------------------------
  // Control register one bit positions
  // ----------------------------------------
  localparam int BIT_STOP_AFTER_EVENT  = 2;
  localparam int BIT_PANEL_RESET_SCOPE = 4;
  localparam int BIT_BERR_TERMINATE    = 5;
  localparam int BIT_ALIGN_EVEN        = 6;

  // ----------------------------------------
  // Status register one bit positions
  // ----------------------------------------
  localparam int BIT_ST_LOCAL_READY  = 0;
  localparam int BIT_ST_CHAIN_READY  = 1;
  localparam int BIT_ST_LOCAL_BUSY   = 2;
  localparam int BIT_ST_CHAIN_BUSY   = 3;
  localparam int BIT_ST_SLOT_MISSING = 4;
  localparam int BIT_ST_PURGED       = 5;
  localparam int BIT_ST_TERM_ON      = 6;
  localparam int BIT_ST_TERM_OFF     = 7;
  localparam int BIT_ST_THRESHOLD    = 8;

endpackage

// >>> bench/cpu_bus_model.sv
// Stand-in for the bus master that reaches the control register group.
// Assumes the register port contract: one-cycle strobes, acknowledge one
// cycle after the strobe edge, read data valid with the acknowledge.
module cpu_bus_model
  import ctrl_regs_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reg_ack_in,
  input  wire logic [15:0] reg_rdata_in,
  output logic      [15:0] reg_addr_out,
  output logic             reg_write_out,
  output logic             reg_read_out,
  output logic      [15:0] reg_wdata_out,
  output logic             iack_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Strobes rest low; the data lines rest on a pattern, not on the last value.
  initial
  begin
    reg_addr_out  = 16'h0000;
    reg_write_out = 1'b0;
    reg_read_out  = 1'b0;
    reg_wdata_out = 16'ha5a5;
    iack_out      = 1'b0;
  end

  // ----------------------------------------
  // One access
  // ----------------------------------------
  // The strobe is a single-cycle pulse, so it drops after the taking edge; the
  // answer is waited for under a small bound.
  task automatic access(input logic [15:0] addr, input logic wr, input logic rd, input logic ak,
                        input logic [15:0] data, output logic [15:0] rdata);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    reg_addr_out  = addr;
    reg_wdata_out = data;
    reg_write_out = wr;
    reg_read_out  = rd;
    iack_out      = ak;
    @(posedge clk_in);
    #1;
    reg_write_out = 1'b0;
    reg_read_out  = 1'b0;
    iack_out      = 1'b0;
    reg_wdata_out = ~data;
    while (reg_ack_in !== 1'b1 && n < 4)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    rdata = (reg_ack_in === 1'b1) ? reg_rdata_in : 16'hxxxx;
  endtask
endmodule

// >>> bench/tb_vme_module_control_registers.sv
// Self-checking bench for the control register group.
// Assumes the design package and the bus master stand-in are compiled first.
module tb_vme_module_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  import ctrl_regs_pkg::*;

  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic clk_in, reset_in, reg_write_in, reg_read_in, iack_in, reg_ack_out, irq_raised_in;
  logic converting_in, buffer_full_in, memory_test_in, bus_error_event_in, purged_in;
  logic slot_address_missing_in, chain_ready_line_in, chain_busy_line_in, term_all_on_in;
  logic term_all_off_in, panel_reset_in, module_reset_out, data_reset_out;
  logic stop_after_first_event_out, bus_error_terminate_enable_out, align_even_out;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rotary_base_in, base_address_out;
  logic [4:0]  events_stored_in, event_trigger_in;
  logic [7:0]  chain_address_out;
  logic [2:0]  irq_level_out, cur_level;
  logic [15:0] r;
  int n_errors, checks_done, cycles, cnt;

  module_control_regs u_dut (.*);

  cpu_bus_model u_cpu (.clk_in(clk_in), .reg_ack_in(reg_ack_out), .reg_rdata_in(reg_rdata_out),
                       .reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in),
                       .reg_read_out(reg_read_in), .reg_wdata_out(reg_wdata_in), .iack_out(iack_in));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // The whole run needs well under a thousand cycles; a hang ends it at twice that.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_cpu.access(a, 1'b1, 1'b0, 1'b0, d, r);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp, input string what);
    u_cpu.access(a, 1'b0, 1'b1, 1'b0, 16'h0000, r);
    check16(what, exp, r);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Drives every status source, lets the pin synchronisers settle, reads back.
  task automatic st_case(input logic [4:0] ev, input logic [4:0] tr, input logic irq, input logic [8:0] s);
    logic lb;
    logic lr;
    {converting_in, buffer_full_in, memory_test_in, chain_ready_line_in, chain_busy_line_in,
     slot_address_missing_in, purged_in, term_all_on_in, term_all_off_in} = s;
    events_stored_in = ev;
    event_trigger_in = tr;
    irq_raised_in    = irq;
    lb = |s[8:6];
    lr = (ev != 5'h00);
    waitc(5);
    rdc(OFF_STATUS_ONE, {7'h00, (tr >= ev) && irq && (cur_level != 3'h0), s[0], s[1], s[2], s[3],
        s[4] | lb, lb, s[5] | lr, lr}, "status");
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {reset_in, irq_raised_in, converting_in, buffer_full_in, memory_test_in} = 5'h10;
    {bus_error_event_in, purged_in, slot_address_missing_in, chain_ready_line_in} = 4'h0;
    {chain_busy_line_in, term_all_on_in, term_all_off_in, panel_reset_in} = 4'h0;
    {events_stored_in, event_trigger_in, cur_level} = 13'h0000;
    rotary_base_in = 16'h5a3c;
    {n_errors, checks_done, cycles} = 0;
    repeat (12) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    waitc(4);
    check16("chain out", 16'h00aa, {8'h00, chain_address_out});
    rdc(OFF_CHAIN_ADDRESS, 16'h00aa, "chain addr");
    rdc(OFF_SET_ONE, 16'h0000, "set one");
    rdc(OFF_IRQ_LEVEL, 16'h0000, "irq level");
    rdc(OFF_IRQ_VECTOR, 16'h0000, "vector");
    rdc(OFF_CONTROL_ONE, 16'h0000, "control one");
    check16("base rotary", 16'h5a3c, base_address_out);
    $display("test reset_values done");
    wr(OFF_CHAIN_ADDRESS, 16'hff55);
    rdc(OFF_CHAIN_ADDRESS, 16'h0055, "chain addr");
    check16("chain out", 16'h0055, {8'h00, chain_address_out});
    wr(16'h1000, 16'hffff);
    rdc(16'h1000, 16'h0000, "unmapped");
    rdc(OFF_SINGLE_SHOT, 16'h0000, "single shot read");
    $display("test chain_and_unmapped done");
    wr(OFF_RELOCATE_HIGH, 16'hff12);
    wr(OFF_RELOCATE_LOW, 16'hab34);
    rdc(OFF_RELOCATE_HIGH, 16'h0012, "reloc high");
    rdc(OFF_RELOCATE_LOW, 16'h0034, "reloc low");
    wr(OFF_SET_ONE, 16'h0018);
    rdc(OFF_SET_ONE, 16'h0018, "set one");
    rdc(OFF_CLEAR_ONE, 16'h0018, "clear one");
    waitc(3);
    check16("base reloc", 16'h1234, base_address_out);
    wr(OFF_SET_ONE, 16'h0000);
    rdc(OFF_SET_ONE, 16'h0018, "set zero keeps");
    wr(OFF_CLEAR_ONE, 16'h0008);
    rdc(OFF_SET_ONE, 16'h0010, "clear flag");
    wr(OFF_CLEAR_ONE, 16'h0010);
    waitc(3);
    check16("base rotary", 16'h5a3c, base_address_out);
    $display("test set_clear done");
    @(posedge clk_in);
    #1;
    bus_error_event_in = 1'b1;
    @(posedge clk_in);
    #1;
    bus_error_event_in = 1'b0;
    rdc(OFF_SET_ONE, 16'h0008, "bus error flag");
    wr(OFF_SET_ONE, 16'h0090);
    waitc(4);
    check1("hold reset", 1'b1, module_reset_out);
    wr(OFF_CLEAR_ONE, 16'h0080);
    waitc(2);
    check1("hold released", 1'b0, module_reset_out);
    rdc(OFF_SET_ONE, 16'h0010, "soft reset clears flag only");
    wr(OFF_CLEAR_ONE, 16'h0010);
    $display("test hold_reset done");
    wr(OFF_SINGLE_SHOT, 16'h0000);
    cnt = 0;
    repeat (6)
    begin
      @(posedge clk_in);
      #1;
      cnt += (module_reset_out === 1'b1);
    end
    check16("single shot pulses", 16'h0001, cnt[15:0]);
    $display("test single_shot done");
    wr(OFF_IRQ_LEVEL, 16'hfffd);
    cur_level = 3'h5;
    rdc(OFF_IRQ_LEVEL, 16'h0005, "irq level");
    check16("irq out", 16'h0005, {13'h0000, irq_level_out});
    wr(OFF_IRQ_VECTOR, 16'hab5c);
    rdc(OFF_IRQ_VECTOR, 16'h005c, "vector");
    u_cpu.access(16'h0000, 1'b0, 1'b0, 1'b1, 16'h0000, r);
    check16("iack vector", 16'h005c, r);
    $display("test interrupt done");
    wr(OFF_CONTROL_ONE, 16'hff80);
    rdc(OFF_CONTROL_ONE, 16'h0000, "control high");
    wr(OFF_CONTROL_ONE, 16'hfff4);
    rdc(OFF_CONTROL_ONE, 16'h0074, "control one");
    check16("config outs", 16'h0007, {13'h0000, stop_after_first_event_out,
            bus_error_terminate_enable_out, align_even_out});
    wr(OFF_CONTROL_ONE, 16'h0000);
    check16("config outs", 16'h0000, {13'h0000, stop_after_first_event_out,
            bus_error_terminate_enable_out, align_even_out});
    $display("test control done");
    st_case(5'h00, 5'h00, 1'b0, 9'h000);
    st_case(5'h03, 5'h05, 1'b1, 9'h100);
    st_case(5'h01, 5'h00, 1'b1, 9'h080);
    st_case(5'h04, 5'h04, 1'b1, 9'h040);
    st_case(5'h00, 5'h02, 1'b0, 9'h020);
    st_case(5'h02, 5'h01, 1'b1, 9'h010);
    st_case(5'h00, 5'h00, 1'b0, 9'h008);
    st_case(5'h00, 5'h00, 1'b0, 9'h004);
    st_case(5'h00, 5'h00, 1'b0, 9'h002);
    st_case(5'h00, 5'h00, 1'b0, 9'h001);
    st_case(5'h00, 5'h00, 1'b0, 9'h000);
    wr(OFF_STATUS_ONE, 16'hffff);
    rdc(OFF_STATUS_ONE, 16'h0000, "status write");
    $display("test status done");
    panel_reset_in = 1'b1;
    waitc(5);
    check1("panel data reset", 1'b1, data_reset_out);
    check1("panel no soft", 1'b0, module_reset_out);
    panel_reset_in = 1'b0;
    waitc(5);
    wr(OFF_SET_ONE, 16'h0008);
    wr(OFF_CONTROL_ONE, 16'h0010);
    panel_reset_in = 1'b1;
    waitc(5);
    check1("panel soft reset", 1'b1, module_reset_out);
    panel_reset_in = 1'b0;
    waitc(5);
    rdc(OFF_SET_ONE, 16'h0000, "soft clears flag");
    rdc(OFF_CONTROL_ONE, 16'h0010, "scope kept");
    reset_in = 1'b1;
    waitc(3);
    reset_in = 1'b0;
    rdc(OFF_CONTROL_ONE, 16'h0000, "hard clears scope");
    rdc(OFF_CHAIN_ADDRESS, 16'h00aa, "chain addr");
    $display("test panel_and_hard_reset done");
    conclude();
  end
endmodule
